// *** pkg/seq_pkg.sv ***
/*
  Shared constants and types of the program sequencer.
  Assumes a 32-bit word-addressed program space.
*/
package seq_pkg;

  // ----------------------------------------
  // Widths and sizes
  // ----------------------------------------
  localparam int PC_W = 32;
  localparam int BTB_ENTRIES = 32;
  localparam int BTB_WAYS = 4;
  localparam int BTB_SETS = BTB_ENTRIES / BTB_WAYS;
  localparam int SET_W = 3;
  localparam int WAY_W = 2;
  localparam int TAG_W = PC_W - SET_W;
  localparam logic [PC_W-1:0] PC_STEP = 32'h0000_0001;
  localparam logic [31:0] LC_STEP = 32'h0000_0001;
  localparam logic [WAY_W-1:0] WAY_STEP = 2'h1;

  // ----------------------------------------
  // Pipeline depths and refill counter
  // ----------------------------------------
  localparam logic [3:0] DEPTH_SMALL = 4'h8;
  localparam logic [3:0] DEPTH_LARGE = 4'hA;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // ----------------------------------------
  // Register byte offsets and fields
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LC_ZERO = 8'h04;
  localparam logic [7:0] ADDR_LC_ONE = 8'h08;
  localparam logic [7:0] ADDR_CRR = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int CTRL_BTB_EN_BIT = 0;
  localparam int CTRL_DEPTH_BIT = 1;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // Branch descriptors
  // ----------------------------------------
  typedef enum logic [3:0] {
    KIND_JUMP = 4'h1,
    KIND_CALL = 4'h2,
    KIND_RETURN = 4'h4,
    KIND_LOOP = 4'h8
  } br_kind_e;

  typedef enum logic [2:0] {
    COND_ALWAYS = 3'h0,
    COND_FLAG = 3'h1,
    LOOP_ZERO_NOT_EXPIRED_COND = 3'h2,
    LOOP_ONE_NOT_EXPIRED_COND = 3'h3,
    LOOP_ZERO_EXPIRED_COND = 3'h4,
    LOOP_ONE_EXPIRED_COND = 3'h5
  } br_cond_e;

  typedef enum logic [1:0] {
    OPT_NONE = 2'h0,
    OPT_PREDICTED = 2'h1,
    NOT_PREDICTED_BRANCH_OPTION = 2'h2
  } br_opt_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_REFILL = 2'b10
  } seq_state_e;

endpackage

// *** logic/branch_target_buffer.sv ***
/*
  Branch target buffer: 32 entries, 4 ways, round-robin victim per set.
  Assumes the caller gates lookups and updates with the enable.
*/
`timescale 1ns/10ps
module branch_target_buffer
  import seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [PC_W-1:0] look_addr_i,
  output logic hit_o,
  output logic [PC_W-1:0] target_o,
  input wire logic upd_i,
  input wire logic inv_i,
  input wire logic [PC_W-1:0] upd_addr_i,
  input wire logic [PC_W-1:0] upd_target_i
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [BTB_ENTRIES-1:0] valid;
    logic [BTB_ENTRIES-1:0][TAG_W-1:0] tag;
    logic [BTB_ENTRIES-1:0][PC_W-1:0] target;
    logic [BTB_SETS-1:0][WAY_W-1:0] victim;
  } btb_s;

  btb_s st_reg;
  btb_s st_next;

  // Entry index of a set and way
  function automatic int entry(input logic [SET_W-1:0] s, input int w);
    entry = int'(s) * BTB_WAYS + w;
  endfunction

  // Combinational lookup, one set searched in all ways
  always_comb begin
    logic [SET_W-1:0] s;
    s = look_addr_i[SET_W-1:0];
    hit_o = 1'b0;
    target_o = '0;
    for (int w = 0; w < BTB_WAYS; w++) begin
      if (st_reg.valid[entry(s, w)] && st_reg.tag[entry(s, w)] == look_addr_i[PC_W-1:SET_W]) begin
        hit_o = 1'b1;
        target_o = st_reg.target[entry(s, w)];
      end
    end
  end

  // Update: reuse a matching way, else take the set's victim
  always_comb begin
    logic [SET_W-1:0] s;
    logic found;
    int way;
    s = upd_addr_i[SET_W-1:0];
    found = 1'b0;
    way = int'(st_reg.victim[s]);
    st_next = st_reg;
    for (int w = 0; w < BTB_WAYS; w++) begin
      if (st_reg.valid[entry(s, w)] && st_reg.tag[entry(s, w)] == upd_addr_i[PC_W-1:SET_W]) begin
        found = 1'b1;
        way = w;
      end
    end
    if (upd_i) begin
      st_next.valid[entry(s, way)] = 1'b1;
      st_next.tag[entry(s, way)] = upd_addr_i[PC_W-1:SET_W];
      st_next.target[entry(s, way)] = upd_target_i;
      if (!found) begin
        st_next.victim[s] = st_reg.victim[s] + WAY_STEP;
      end
    end else if (inv_i && found) begin
      // Entry that predicted a taken branch wrongly is dropped
      st_next.valid[entry(s, way)] = 1'b0;
    end
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// *** logic/branch_loop_sequencer.sv ***
/*
  Program sequencer: fetch address, branch resolution, call link,
  two loop counters, interlock and a Wishbone register slave.
  Assumes decode reports each resolved branch with the address that
  was fetched after it, and memories answer fetches with an ack.
*/
// What this block does
// - Interlocked pipeline, depth 8 or 10
// - Stall on hazards, results always correct
// - One fetch, two data accesses per cycle
// - Target buffer: 32 entries, 4-way
// - Stored target steers the next fetch
// - Buffer used only when enabled and predicted
// - No suffix means predicted; honour suffixes
// - Not-predicted branches never write buffer
// - Call writes return address to one register
// - Return jumps to the link register
// - No delayed branches; younger instructions flushed
// - Loop-closing branch costs no extra cycles only when the next fetch already matches its outcome; otherwise a refill
// - Two loop counters, four loop conditions
// - No loop stack, no PC stack
// - Loop: load, label, conditional jump back
// - Taken loop jump still fetches next instruction
`timescale 1ns/10ps
module branch_loop_sequencer
  import seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic fetch_req_o,
  output logic [PC_W-1:0] fetch_addr_o,
  input wire logic fetch_ack_i,
  input wire logic [1:0] data_req_i,
  output logic [1:0] data_grant_o,
  input wire logic hazard_i,
  output logic stall_o,
  input wire logic br_valid_i,
  input wire logic [3:0] br_kind_i,
  input wire logic [1:0] br_option_i,
  input wire logic [2:0] br_cond_i,
  input wire logic br_flag_i,
  input wire logic [PC_W-1:0] br_pc_i,
  input wire logic [PC_W-1:0] br_target_i,
  input wire logic [PC_W-1:0] br_next_pc_i,
  output logic flush_o,
  output logic flush_keep_next_o,
  output logic refilling_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    seq_state_e state;
    logic [3:0] refill_cnt;
    logic [PC_W-1:0] pc;
    logic btb_en;
    logic depth_large;
    logic [31:0] loop_counter_zero;
    logic [31:0] loop_counter_one;
    logic [PC_W-1:0] call_return_register;
    logic ack;
    logic [31:0] rdata;
    logic flush;
    logic keep_next;
  } seq_s;

  localparam seq_s ST_RESET = '{state: ST_RUN, default: '0};

  seq_s st_reg;
  seq_s st_next;

  // Branch buffer interface
  logic btb_hit;
  logic [PC_W-1:0] btb_target;
  logic btb_upd;
  logic btb_inv;

  // Branch resolution terms
  logic accept;
  logic predicted;
  logic taken;
  logic redirect;
  logic [PC_W-1:0] actual_next;
  logic [31:0] lc0_dec;
  logic [31:0] lc1_dec;

  // Bus terms
  logic bus_req;
  logic bus_wr;
  logic [31:0] ctrl_merged; // CTRL write after byte-lane merge against zero

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // Condition value of a loop test against a decremented counter
  function automatic logic not_expired(input logic [31:0] dec);
    not_expired = (dec != WORD_ZERO);
  endfunction

  // ----------------------------------------
  // Branch target buffer
  // ----------------------------------------
  branch_target_buffer u_btb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .look_addr_i(st_reg.pc),
    .hit_o(btb_hit),
    .target_o(btb_target),
    .upd_i(btb_upd),
    .inv_i(btb_inv),
    .upd_addr_i(br_pc_i),
    .upd_target_i(actual_next)
  );

  // ----------------------------------------
  // Interlock and memory ports
  // ----------------------------------------

  // Fetch is held off while a hazard is open; a pending fetch also stalls
  always_comb begin
    fetch_req_o = !hazard_i;
    stall_o = hazard_i | (fetch_req_o & !fetch_ack_i);
    data_grant_o = hazard_i ? 2'h0 : data_req_i;
  end

  // ----------------------------------------
  // Branch resolution
  // ----------------------------------------

  // Resolves the branch decode hands over; only taken when not stalled
  always_comb begin
    accept = br_valid_i & !stall_o;
    // Absent suffix counts as predicted
    predicted = (br_option_i != NOT_PREDICTED_BRANCH_OPTION);
    lc0_dec = st_reg.loop_counter_zero - LC_STEP;
    lc1_dec = st_reg.loop_counter_one - LC_STEP;
    case (br_cond_e'(br_cond_i))
      COND_ALWAYS: taken = 1'b1;
      COND_FLAG: taken = br_flag_i;
      LOOP_ZERO_NOT_EXPIRED_COND: taken = not_expired(lc0_dec);
      LOOP_ONE_NOT_EXPIRED_COND: taken = not_expired(lc1_dec);
      LOOP_ZERO_EXPIRED_COND: taken = !not_expired(lc0_dec);
      LOOP_ONE_EXPIRED_COND: taken = !not_expired(lc1_dec);
      default: taken = 1'b0;
    endcase
    // Return takes its target from the link register
    if (!taken) begin
      actual_next = br_pc_i + PC_STEP;
    end else if (br_kind_i == KIND_RETURN) begin
      actual_next = st_reg.call_return_register;
    end else begin
      actual_next = br_target_i;
    end
    // Any path other than the one fetched is a redirect
    redirect = accept & (actual_next != br_next_pc_i);
    // Buffer touched only when enabled and the branch is predicted
    btb_upd = accept & st_reg.btb_en & predicted & taken;
    btb_inv = accept & st_reg.btb_en & predicted & !taken;
  end

  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------

  // Write lands on the edge where ack is seen high
  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i;
    bus_wr = bus_req & wb_we_i & st_reg.ack;
    // A function result cannot be bit-selected, so the merge lands in a net first
    ctrl_merged = merge(WORD_ZERO, wb_dat_i, wb_sel_i);
    wb_ack_o = st_reg.ack;
    wb_dat_o = st_reg.rdata;
    flush_o = st_reg.flush;
    flush_keep_next_o = st_reg.keep_next;
    fetch_addr_o = st_reg.pc;
    refilling_o = (st_reg.state == ST_REFILL);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.flush = 1'b0;
    st_next.keep_next = 1'b0;

    // Sequential fetch, or the stored target on a hit
    if (fetch_req_o && fetch_ack_i) begin
      if (st_reg.btb_en && btb_hit) begin
        st_next.pc = btb_target;
      end else begin
        st_next.pc = st_reg.pc + PC_STEP;
      end
    end

    // Loop tests count down their counter each time
    if (accept && br_cond_i == LOOP_ZERO_NOT_EXPIRED_COND) begin
      st_next.loop_counter_zero = lc0_dec;
    end
    if (accept && br_cond_i == LOOP_ZERO_EXPIRED_COND) begin
      st_next.loop_counter_zero = lc0_dec;
    end
    if (accept && br_cond_i == LOOP_ONE_NOT_EXPIRED_COND) begin
      st_next.loop_counter_one = lc1_dec;
    end
    if (accept && br_cond_i == LOOP_ONE_EXPIRED_COND) begin
      st_next.loop_counter_one = lc1_dec;
    end

    // Call overwrites the single link; no stack behind it
    if (accept && taken && br_kind_i == KIND_CALL) begin
      st_next.call_return_register = br_pc_i + PC_STEP;
    end

    // Wrong path: flush younger work and refetch
    if (redirect) begin
      st_next.pc = actual_next;
      st_next.flush = 1'b1;
      // Slot paired with a taken loop jump survives the flush
      st_next.keep_next = taken && br_kind_i == KIND_LOOP;
      st_next.state = ST_REFILL;
      st_next.refill_cnt = (st_reg.depth_large ? DEPTH_LARGE : DEPTH_SMALL) - CNT_ONE;
    end else begin
      case (st_reg.state)
        ST_RUN: st_next.state = ST_RUN;
        ST_REFILL: begin
          // Each accepted fetch moves one stage closer to full
          if (fetch_req_o && fetch_ack_i) begin
            st_next.refill_cnt = st_reg.refill_cnt - CNT_ONE;
            if (st_reg.refill_cnt == CNT_ONE) begin
              st_next.state = ST_RUN;
            end
          end
        end
        default: st_next.state = ST_RUN;
      endcase
    end

    // Bus: one cycle of ack per request, read data captured with it
    st_next.ack = bus_req & !st_reg.ack;
    if (bus_req && !st_reg.ack) begin
      case (wb_adr_i)
        ADDR_CTRL: st_next.rdata = {30'h0000_0000, st_reg.depth_large, st_reg.btb_en};
        ADDR_LC_ZERO: st_next.rdata = st_reg.loop_counter_zero;
        ADDR_LC_ONE: st_next.rdata = st_reg.loop_counter_one;
        ADDR_CRR: st_next.rdata = st_reg.call_return_register;
        ADDR_PC: st_next.rdata = st_reg.pc;
        ADDR_STATUS: st_next.rdata = {27'h000_0000, refilling_o, st_reg.refill_cnt};
        default: st_next.rdata = WORD_ZERO;
      endcase
    end

    // Software writes win over a same-cycle count or call
    if (bus_wr) begin
      case (wb_adr_i)
        ADDR_CTRL: begin
          st_next.btb_en = ctrl_merged[CTRL_BTB_EN_BIT];
          st_next.depth_large = ctrl_merged[CTRL_DEPTH_BIT];
        end
        ADDR_LC_ZERO: st_next.loop_counter_zero = merge(st_reg.loop_counter_zero, wb_dat_i, wb_sel_i);
        ADDR_LC_ONE: st_next.loop_counter_one = merge(st_reg.loop_counter_one, wb_dat_i, wb_sel_i);
        ADDR_CRR: st_next.call_return_register = merge(st_reg.call_return_register, wb_dat_i, wb_sel_i);
        default: st_next.ack = st_next.ack;
      endcase
    end
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence redirect_s;
    redirect;
  endsequence

  sequence refill_start_s;
    flush_o && refilling_o;
  endsequence

  np_no_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && br_option_i == NOT_PREDICTED_BRANCH_OPTION |-> !btb_upd && !btb_inv)
    else $error("not-predicted branch touched buffer");

  btb_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (btb_upd || btb_inv) |-> st_reg.btb_en && br_option_i != NOT_PREDICTED_BRANCH_OPTION)
    else $error("buffer used while disabled");

  call_link_a: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && taken && br_kind_i == KIND_CALL && !bus_wr
    |=> st_reg.call_return_register == $past(br_pc_i) + PC_STEP)
    else $error("call link wrong");

  return_jump_a: assert property (@(posedge clk_i) disable iff (rst_i)
    redirect && taken && br_kind_i == KIND_RETURN
    |=> fetch_addr_o == $past(st_reg.call_return_register))
    else $error("return target wrong");

  flush_refetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    redirect_s |=> refill_start_s ##0 fetch_addr_o == $past(actual_next))
    else $error("flush or refetch missing");

  refill_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    redirect_s |=> st_reg.refill_cnt == (st_reg.depth_large ? DEPTH_LARGE : DEPTH_SMALL) - CNT_ONE)
    else $error("refill length wrong");

  loop_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && br_cond_i == LOOP_ZERO_NOT_EXPIRED_COND && !bus_wr
    |=> st_reg.loop_counter_zero == $past(st_reg.loop_counter_zero) - LC_STEP)
    else $error("loop counter not decremented");

  keep_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    redirect && taken && br_kind_i == KIND_LOOP |=> flush_o && flush_keep_next_o)
    else $error("loop jump dropped next slot");

  stall_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hazard_i && !redirect |-> stall_o && data_grant_o == 2'h0 ##1 $stable(fetch_addr_o))
    else $error("hazard did not stall");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not single");

endmodule

// *** bench/fetch_mem_model.sv ***
/*
  Instruction memory model: answers the sequencer's fetch requests.
  Assumes the bench picks the answer pace through mode_i.
*/
`timescale 1ns/10ps
module fetch_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic req_i,
  output logic ack_o
);
  // ----------------------------------------
  // Answer pace
  // ----------------------------------------
  logic phase_reg; // Toggles every cycle to pace the slow mode

  // Free-running phase for the slow mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  // Fetch block answers on its own, whatever the data ports do
  always_comb begin
    case (mode_i)
      2'h0: ack_o = req_i; // Prompt
      2'h1: ack_o = req_i & phase_reg; // Slow: every other cycle
      default: ack_o = 1'b0; // Held off, so the pipeline must stall
    endcase
  end
endmodule

// *** bench/branch_loop_sequencer_test.sv ***
/*
  Self-checking bench of the program sequencer with its memory model.
  Assumes registered flush pulses; bus waits end only at the watchdog.
*/
`timescale 1ns/10ps
module branch_loop_sequencer_test;
  import seq_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_i, rst_i, cyc, stb, we, ack, hazard, fack, freq, flush, keep, stall, refl, bv, bflag;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, faddr, bpc, btgt, bnxt;
  logic [3:0] bkind;
  logic [2:0] bcond;
  logic [1:0] bopt, dreq, dgnt, mmode;
  int failures, n_compared;

  branch_loop_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .fetch_req_o(freq),
    .fetch_addr_o(faddr), .fetch_ack_i(fack), .data_req_i(dreq), .data_grant_o(dgnt), .hazard_i(hazard),
    .stall_o(stall), .br_valid_i(bv), .br_kind_i(bkind), .br_option_i(bopt), .br_cond_i(bcond),
    .br_flag_i(bflag), .br_pc_i(bpc), .br_target_i(btgt), .br_next_pc_i(bnxt), .flush_o(flush),
    .flush_keep_next_o(keep), .refilling_o(refl));

  fetch_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mmode), .req_i(freq), .ack_o(fack));

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; a dead slave is caught by the watchdog, not here
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask

  // Holds the branch until an edge with no stall; returns at the next falling edge
  task automatic branch(input logic [3:0] k, input logic [1:0] o, input logic [2:0] c,
      input logic [31:0] p, input logic [31:0] t, input logic [31:0] x);
    logic ok;
    @(posedge clk_i);
    {bv, bkind, bopt, bcond, bpc, btgt, bnxt} <= {1'b1, k, o, c, p, t, x};
    do begin
      @(negedge clk_i);
      ok = !stall;
      @(posedge clk_i);
    end while (!ok);
    bv <= 1'b0;
    @(negedge clk_i);
  endtask

  // Redirect fetch to p with a branch that never touches the buffer, then see what follows p
  task automatic follow(input logic [31:0] p, input logic [31:0] exp);
    branch(KIND_JUMP, NOT_PREDICTED_BRANCH_OPTION, COND_ALWAYS, 32'h80, p, 32'hFFFF_FFF0);
    check("redirect", faddr, p);
    @(negedge clk_i);
    check("fetch after", faddr, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int a = 0; a <= 8'h18; a += 4) begin
      rd("reset reg", 8'(a), 32'h0);
    end
    wr(ADDR_CTRL, 32'h3);
    rd("ctrl", ADDR_CTRL, 32'h3);
    wr(ADDR_PC, 32'h55);
    rd("fetch addr ro", ADDR_PC, 32'h0);
    wr(ADDR_CTRL, 32'h0);
  endtask

  task automatic t_hazard();
    logic [31:0] f;
    @(posedge clk_i);
    dreq <= 2'b11;
    hazard <= 1'b1;
    @(negedge clk_i);
    f = faddr;
    check("fetch req", freq, 1'b0);
    check("grant", dgnt, 2'b00);
    check("stall", stall, 1'b1);
    @(negedge clk_i);
    check("held addr", faddr, f);
    @(posedge clk_i);
    hazard <= 1'b0;
    @(negedge clk_i);
    check("grant", dgnt, 2'b11);
    check("fetch with data", {freq, stall}, 2'b10);
  endtask

  task automatic t_call();
    branch(KIND_CALL, OPT_NONE, COND_ALWAYS, 32'h500, 32'h600, 32'hFFFF_FFF0);
    check("call target", faddr, 32'h600);
    check("flush", flush, 1'b1);
    rd("link", ADDR_CRR, 32'h501);
    branch(KIND_CALL, OPT_PREDICTED, COND_ALWAYS, 32'h700, 32'h800, 32'hFFFF_FFF0);
    rd("link", ADDR_CRR, 32'h701);
    branch(KIND_RETURN, OPT_NONE, COND_ALWAYS, 32'h810, 32'h0, 32'hFFFF_FFF0);
    check("return", faddr, 32'h701);
    check("flush", flush, 1'b1);
    // Software puts back the link it saved before the second call
    wr(ADDR_CRR, 32'h501);
    branch(KIND_RETURN, OPT_NONE, COND_ALWAYS, 32'h610, 32'h0, 32'hFFFF_FFF0);
    check("return", faddr, 32'h501);
    branch(KIND_JUMP, OPT_NONE, COND_FLAG, 32'h900, 32'hA00, 32'hA00);
    check("flag false", faddr, 32'h901);
  endtask

  task automatic t_loops();
    logic [7:0] a;
    // Each of the four loop conditions on a counter of 2
    for (int i = 0; i < 4; i++) begin
      a = i[0] ? ADDR_LC_ONE : ADDR_LC_ZERO;
      wr(a, 32'h2);
      branch(KIND_LOOP, OPT_NONE, 3'(2 + i), 32'h40, 32'h30, 32'hFFFF_FFF0);
      check("loop next", faddr, (i < 2) ? 32'h30 : 32'h41);
      if (i < 2) check("keep next", keep, 1'b1);
      rd("counter", a, 32'h1);
    end
    // Well-predicted loop-closing jump costs nothing
    wr(ADDR_LC_ZERO, 32'h2);
    branch(KIND_LOOP, OPT_NONE, LOOP_ZERO_NOT_EXPIRED_COND, 32'h40, 32'h30, 32'h30);
    check("no flush", flush, 1'b0);
    branch(KIND_LOOP, OPT_NONE, LOOP_ZERO_NOT_EXPIRED_COND, 32'h40, 32'h30, 32'h30);
    check("loop exit", faddr, 32'h41);
    rd("counter", ADDR_LC_ZERO, 32'h0);
    // Third nesting level counted by software, closed by an ordinary flag branch
    for (int sw = 1; sw >= 0; sw--) begin
      bflag <= (sw != 0);
      branch(KIND_JUMP, OPT_NONE, COND_FLAG, 32'h60, 32'h50, 32'hFFFF_FFF0);
      check("soft loop", faddr, (sw != 0) ? 32'h50 : 32'h61);
    end
  endtask

  task automatic t_refill();
    for (int d = 0; d < 2; d++) begin
      wr(ADDR_CTRL, 32'(d * 2));
      branch(KIND_JUMP, NOT_PREDICTED_BRANCH_OPTION, COND_ALWAYS, 32'h20, 32'h900, 32'hFFFF_FFF0);
      // One fetch is taken, then memory holds off so the count freezes
      @(posedge clk_i);
      mmode <= 2'h2;
      rd("refill", ADDR_STATUS, {27'h0, 1'b1, (d ? DEPTH_LARGE : DEPTH_SMALL) - 4'h2});
      check("stall", stall, 1'b1);
      @(posedge clk_i);
      mmode <= 2'h1;
      repeat (30) @(posedge clk_i);
      rd("refill done", ADDR_STATUS, 32'h0);
      mmode <= 2'h0;
    end
    wr(ADDR_CTRL, 32'h0);
  endtask

  task automatic t_btb();
    wr(ADDR_CTRL, 32'h1);
    // No option, predicted, not predicted
    for (int i = 0; i < 3; i++) begin
      branch(KIND_JUMP, 2'(i), COND_ALWAYS, 32'h100 + 32'(i * 16), 32'h200, 32'hFFFF_FFF0);
      follow(32'h100 + 32'(i * 16), (i < 2) ? 32'h200 : 32'h101 + 32'(i * 16));
    end
    wr(ADDR_CTRL, 32'h0);
    follow(32'h100, 32'h101);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Memory held off through reset and the register check so the fetch address stays put for it
  initial begin
    {cyc, stb, we, adr, wdat, hazard, bv, bflag, bkind, bopt, bcond, bpc, btgt, bnxt} = '0;
    dreq = 2'b00;
    mmode = 2'h2;
    failures = 0;
    n_compared = 0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    mmode <= 2'h0;
    t_hazard();
    t_call();
    t_loops();
    t_refill();
    t_btb();
    tally_and_finish();
  end

  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
endmodule
